//--- rtl/dsps_map.vh
// register offsets, fields, reset values and timing for the power sequencer
// assumes inclusion by the sequencer top only
`ifndef DSPS_MAP_VH
`define DSPS_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DSPS_OFF_PCON 12'h000
`define DSPS_OFF_CFG 12'h004
`define DSPS_OFF_WAKE 12'h008
`define DSPS_OFF_CLK 12'h00C
`define DSPS_OFF_GATE 12'h010
`define DSPS_OFF_STAT 12'h014
`define DSPS_OFF_GPR0 12'h020
`define DSPS_GPR_CNT 5

// ----------------------------------------
// power control fields
// ----------------------------------------
`define DSPS_PCON_DPD 0
`define DSPS_PCON_BATOFF 1
`define DSPS_PCON_OVR_BAT 2
`define DSPS_PCON_OVR_FLD 3
`define DSPS_PCON_SLPFLG 8
`define DSPS_PCON_DPDFLG 9

// ----------------------------------------
// configuration fields
// ----------------------------------------
`define DSPS_CFG_AUTO_DIS 0
`define DSPS_CFG_BOD_EN 1
`define DSPS_CFG_SWRST 2
`define DSPS_CFG_LDOD_EN 3
`define DSPS_CFG_LDOA_EN 4
`define DSPS_CFG_RST 5'h18

// ----------------------------------------
// wake enable fields
// ----------------------------------------
`define DSPS_WAKE_PIN 0
`define DSPS_WAKE_FLD 1

// ----------------------------------------
// clock divider
// ----------------------------------------
`define DSPS_DIV_W 3
`define DSPS_DIV_RST 3'h4
`define DSPS_GATE_W 8
`define DSPS_GATE_RST 8'hFF

// ----------------------------------------
// timing: startup about 2.5 ms, wake pin low at least 100 us
// ----------------------------------------
`define DSPS_CLK_HZ 25000000
`define DSPS_STARTUP_US 2500
`define DSPS_WAKE_LOW_US 100
`define DSPS_SLOW_HZ 32768
`define DSPS_CNT_W 17
// synchroniser idle levels: reset and wake pins high, rest low
`define DSPS_SYNC_RST 10'h00C

`endif

//--- rtl/dsps_top.v
// dual source power sequencer: source select, start-up, modes, wake, clocks
// assumes APB master on CLK_IN; slow oscillator tick, pins and comparators asynchronous
//
// What this block does
// - battery powers after reset-pin or field trigger
// - low battery with field uses field supply
// - both sources present prefer battery
// - lost battery switches to field immediately
// - auto switch disable forces battery, comparator off
// - battery switch open until pin edge/field
// - field present closes field switch
// - without field, controller may open battery switch
// - enabled brownout raises interrupt below level
// - off, active, deep-sleep, deep power-down modes set domain power
// - deep power-down flag, regulator states per mode
// - each regulator has its own enable
// - sequencer enables digital then analog regulator
// - release reset after regulator and oscillator
// - start-up takes about 2.5 ms
// - field-only start uses same sequence
// - slow oscillator always runs, never disabled
// - system clock 25 MHz over power of two
// - reset selects divide-by-16 default, about 1.56 MHz
// - per-peripheral gates, fixed sensor clock
// - reset pin, watchdog and software resets
// - deep-sleep wake event set
// - deep power-down wake event set
// - five retained general-purpose registers
// - power control register selects mode, flags
`timescale 1ns/100ps
`include "dsps_map.vh"

module dsps_top (
  input wire CLK_IN,
  input wire RST_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [11:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output reg [31:0] PRDATA_OUT,
  output reg PREADY_OUT,
  output reg PSLVERR_OUT,
  input wire BAT_ABOVE_IN,
  input wire FIELD_ABOVE_IN,
  input wire VDD_LOW_IN,
  input wire EXT_RESET_N_IN,
  input wire WAKE_PIN_IN,
  input wire SLOW_TICK_IN,
  input wire FAST_OSC_OK_IN,
  input wire FLASH_READY_IN,
  input wire TIMER_MATCH_IN,
  input wire WDT_INT_IN,
  input wire WDT_RST_IN,
  input wire START_INT_IN,
  input wire CORE_SLEEP_IN,
  output reg BAT_SWITCH_OUT,
  output reg FIELD_SWITCH_OUT,
  output reg COMPARATOR_EN_OUT,
  output reg LDO_DIG_OUT,
  output reg LDO_ANA_OUT,
  output reg DPD_FLAG_OUT,
  output reg [2:0] MODE_OUT,
  output reg SYS_RESET_OUT,
  output reg BOOT_OK_OUT,
  output reg BOD_IRQ_OUT,
  output reg SYS_CLK_EN_OUT,
  output reg [`DSPS_GATE_W-1:0] PERIPH_CLK_EN_OUT,
  output reg SENSOR_CLK_EN_OUT
);

  // ----------------------------------------
  // modes and timing
  // ----------------------------------------
  localparam [2:0] M_OFF = 3'h0;
  localparam [2:0] M_SEQ1 = 3'h1;
  localparam [2:0] M_SEQ2 = 3'h2;
  localparam [2:0] M_ACT = 3'h3;
  localparam [2:0] M_SLP = 3'h4;
  localparam [2:0] M_DSLP = 3'h5;
  localparam [2:0] M_DPD = 3'h6;
  localparam integer STARTUP_CYC = `DSPS_CLK_HZ / 1000000 * `DSPS_STARTUP_US;
  localparam integer WAKE_CYC = `DSPS_CLK_HZ / 1000000 * `DSPS_WAKE_LOW_US;
  localparam integer HALF_CYC = STARTUP_CYC / 2;
  localparam [`DSPS_CNT_W-1:0] STARTUP_N = STARTUP_CYC[`DSPS_CNT_W-1:0];
  localparam [`DSPS_CNT_W-1:0] HALF_N = HALF_CYC[`DSPS_CNT_W-1:0];
  localparam [`DSPS_CNT_W-1:0] WAKE_N = WAKE_CYC[`DSPS_CNT_W-1:0];
  localparam [`DSPS_CNT_W-1:0] CNT_ZERO = {`DSPS_CNT_W{1'b0}};
  localparam [`DSPS_CNT_W-1:0] CNT_ONE = {{(`DSPS_CNT_W-1){1'b0}}, 1'b1};

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  reg [9:0] s1_r;
  reg [9:0] s2_r;
  wire [9:0] async_in = {FLASH_READY_IN, FAST_OSC_OK_IN, VDD_LOW_IN, FIELD_ABOVE_IN,
                         BAT_ABOVE_IN, SLOW_TICK_IN, WAKE_PIN_IN, EXT_RESET_N_IN,
                         TIMER_MATCH_IN, START_INT_IN};
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      s1_r <= `DSPS_SYNC_RST;
      s2_r <= `DSPS_SYNC_RST;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
    end
  end
  wire start_s = s2_r[0];
  wire tmr_s = s2_r[1];
  wire rstn_s = s2_r[2];
  wire wake_s = s2_r[3];
  wire tick_s = s2_r[4];
  wire bat_s = s2_r[5];
  wire fld_s = s2_r[6];
  wire low_s = s2_r[7];
  wire osc_s = s2_r[8];
  wire fls_s = s2_r[9];

  reg rstn_d_r;
  reg tick_d_r;
  reg tmr_d_r;
  wire rstn_rise = rstn_s & ~rstn_d_r;
  wire rstn_fall = ~rstn_s & rstn_d_r;
  wire tick_rise = tick_s & ~tick_d_r;
  wire tmr_rise = tmr_s & ~tmr_d_r;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [3:0] pcon_r;
  reg slp_flag_r;
  reg dpd_flag_r;
  reg [4:0] cfg_r;
  reg [1:0] wake_en_r;
  reg [`DSPS_DIV_W-1:0] div_r;
  reg [`DSPS_GATE_W-1:0] gate_r;
  reg [31:0] gpr_r [0:`DSPS_GPR_CNT-1];
  reg armed_r;
  reg [2:0] mode_r;
  reg [`DSPS_CNT_W-1:0] cnt_r;
  reg [`DSPS_CNT_W-1:0] wcnt_r;
  reg [6:0] divc_r;

  function is_gpr;
    input [11:0] a;
    begin
      is_gpr = (a >= `DSPS_OFF_GPR0) &&
               (a < `DSPS_OFF_GPR0 + 12'h004 * `DSPS_GPR_CNT);
    end
  endfunction

  wire acc = PSEL_IN & PENABLE_IN & PREADY_OUT;
  wire wr = acc & PWRITE_IN;
  wire [2:0] gidx = PADDR_IN[4:2];
  wire mapped = (PADDR_IN == `DSPS_OFF_PCON) || (PADDR_IN == `DSPS_OFF_CFG) ||
                (PADDR_IN == `DSPS_OFF_WAKE) || (PADDR_IN == `DSPS_OFF_CLK) ||
                (PADDR_IN == `DSPS_OFF_GATE) || (PADDR_IN == `DSPS_OFF_STAT) ||
                is_gpr(PADDR_IN);

  // ----------------------------------------
  // source selection
  // ----------------------------------------
  wire auto_dis = cfg_r[`DSPS_CFG_AUTO_DIS];
  wire bat_ok = auto_dis | (bat_s & ~pcon_r[`DSPS_PCON_OVR_BAT]);
  wire fld_ok = fld_s & ~pcon_r[`DSPS_PCON_OVR_FLD];
  wire use_bat = armed_r & bat_ok & ~pcon_r[`DSPS_PCON_BATOFF];
  wire use_fld = fld_ok & ~(use_bat & ~auto_dis) & ~use_bat;
  wire powered = use_bat | use_fld;

  // ----------------------------------------
  // wake and reset events
  // ----------------------------------------
  wire wake_low = (wcnt_r >= WAKE_N);
  wire sw_rst = wr & (PADDR_IN == `DSPS_OFF_CFG) & PWDATA_IN[`DSPS_CFG_SWRST];
  wire any_rst = rstn_fall | WDT_RST_IN | sw_rst;
  wire dslp_wake = rstn_fall | tmr_rise | WDT_INT_IN | WDT_RST_IN | ~wake_s |
                   (wake_en_r[`DSPS_WAKE_FLD] & fld_s) | start_s;
  wire dpd_wake = rstn_fall | tmr_rise | (wake_en_r[`DSPS_WAKE_PIN] & wake_low) |
                  (wake_en_r[`DSPS_WAKE_FLD] & fld_s);

  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      rstn_d_r <= 1'b1;
      tick_d_r <= 1'b0;
      tmr_d_r <= 1'b0;
      armed_r <= 1'b0;
      wcnt_r <= CNT_ZERO;
    end else begin
      rstn_d_r <= rstn_s;
      tick_d_r <= tick_s;
      tmr_d_r <= tmr_s;
      if (rstn_rise | fld_s)
        armed_r <= 1'b1;
      else if (pcon_r[`DSPS_PCON_BATOFF] & ~fld_s)
        armed_r <= 1'b0;
      if (wake_s)
        wcnt_r <= CNT_ZERO;
      else if (!wake_low)
        wcnt_r <= wcnt_r + CNT_ONE;
    end
  end

  // ----------------------------------------
  // power state machine
  // ----------------------------------------
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      mode_r <= M_OFF;
      cnt_r <= CNT_ZERO;
      slp_flag_r <= 1'b0;
      dpd_flag_r <= 1'b0;
    end else begin
      if (wr && PADDR_IN == `DSPS_OFF_PCON) begin
        if (PWDATA_IN[`DSPS_PCON_SLPFLG])
          slp_flag_r <= 1'b0;
        if (PWDATA_IN[`DSPS_PCON_DPDFLG])
          dpd_flag_r <= 1'b0;
      end
      if (!powered) begin
        mode_r <= M_OFF;
        cnt_r <= CNT_ZERO;
      end else begin
        case (mode_r)
          M_OFF: begin
            mode_r <= M_SEQ1;
            cnt_r <= CNT_ZERO;
          end
          M_SEQ1: begin
            cnt_r <= cnt_r + CNT_ONE;
            if (cnt_r >= HALF_N)
              mode_r <= M_SEQ2;
          end
          M_SEQ2: begin
            cnt_r <= cnt_r + CNT_ONE;
            if (cnt_r >= STARTUP_N && fls_s)
              mode_r <= M_ACT;
          end
          M_ACT: begin
            if (CORE_SLEEP_IN) begin
              if (pcon_r[`DSPS_PCON_DPD]) begin
                mode_r <= M_DPD;
                dpd_flag_r <= 1'b1;
              end else begin
                mode_r <= M_DSLP;
                slp_flag_r <= 1'b1;
              end
            end
          end
          M_SLP: begin
            if (!CORE_SLEEP_IN)
              mode_r <= M_ACT;
          end
          M_DSLP: begin
            if (dslp_wake | any_rst)
              mode_r <= M_ACT;
          end
          M_DPD: begin
            if (dpd_wake) begin
              mode_r <= M_SEQ1;
              cnt_r <= CNT_ZERO;
            end
          end
          default: mode_r <= M_OFF;
        endcase
      end
    end
  end

  // ----------------------------------------
  // system clock divider
  // ----------------------------------------
  wire [6:0] div_mask = (7'h01 << div_r) - 7'h01;
  always @(posedge CLK_IN) begin
    if (RST_IN)
      divc_r <= 7'h00;
    else
      divc_r <= divc_r + 7'h01;
  end

  // ----------------------------------------
  // APB register access
  // ----------------------------------------
  integer i;
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      pcon_r <= 4'h0;
      cfg_r <= `DSPS_CFG_RST;
      wake_en_r <= 2'h0;
      div_r <= `DSPS_DIV_RST;
      gate_r <= `DSPS_GATE_RST;
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= 32'h00000000;
      for (i = 0; i < `DSPS_GPR_CNT; i = i + 1)
        gpr_r[i] <= 32'h00000000;
    end else begin
      PREADY_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT;
      PSLVERR_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~mapped;
      if (any_rst)
        div_r <= `DSPS_DIV_RST;
      if (wr) begin
        case (PADDR_IN)
          `DSPS_OFF_PCON: pcon_r <= PWDATA_IN[3:0];
          `DSPS_OFF_CFG: cfg_r <= {PWDATA_IN[4:3], 1'b0, PWDATA_IN[1:0]};
          `DSPS_OFF_WAKE: wake_en_r <= PWDATA_IN[1:0];
          `DSPS_OFF_CLK: if (!any_rst) div_r <= PWDATA_IN[`DSPS_DIV_W-1:0];
          `DSPS_OFF_GATE: gate_r <= PWDATA_IN[`DSPS_GATE_W-1:0];
          default: if (is_gpr(PADDR_IN)) gpr_r[gidx] <= PWDATA_IN;
        endcase
      end
      if (PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~PWRITE_IN) begin
        case (PADDR_IN)
          `DSPS_OFF_PCON:
            PRDATA_OUT <= {22'h0, dpd_flag_r, slp_flag_r, 4'h0, pcon_r};
          `DSPS_OFF_CFG: PRDATA_OUT <= {27'h0, cfg_r};
          `DSPS_OFF_WAKE: PRDATA_OUT <= {30'h0, wake_en_r};
          `DSPS_OFF_CLK: PRDATA_OUT <= {29'h0, div_r};
          `DSPS_OFF_GATE: PRDATA_OUT <= {24'h0, gate_r};
          `DSPS_OFF_STAT:
            PRDATA_OUT <= {21'h0, mode_r, 2'h0, low_s, fld_s, bat_s, armed_r, use_fld, use_bat};
          default: PRDATA_OUT <= is_gpr(PADDR_IN) ? gpr_r[gidx] : 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  wire on_mode = (mode_r == M_ACT) || (mode_r == M_SLP) || (mode_r == M_DSLP);
  wire seq_on = (mode_r == M_SEQ1) || (mode_r == M_SEQ2);
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      BAT_SWITCH_OUT <= 1'b0;
      FIELD_SWITCH_OUT <= 1'b0;
      COMPARATOR_EN_OUT <= 1'b1;
      LDO_DIG_OUT <= 1'b0;
      LDO_ANA_OUT <= 1'b0;
      DPD_FLAG_OUT <= 1'b0;
      MODE_OUT <= M_OFF;
      SYS_RESET_OUT <= 1'b1;
      BOOT_OK_OUT <= 1'b0;
      BOD_IRQ_OUT <= 1'b0;
      SYS_CLK_EN_OUT <= 1'b0;
      PERIPH_CLK_EN_OUT <= {`DSPS_GATE_W{1'b0}};
      SENSOR_CLK_EN_OUT <= 1'b0;
    end else begin
      BAT_SWITCH_OUT <= use_bat;
      FIELD_SWITCH_OUT <= fld_ok;
      COMPARATOR_EN_OUT <= ~auto_dis;
      LDO_DIG_OUT <= (seq_on | on_mode) & cfg_r[`DSPS_CFG_LDOD_EN];
      LDO_ANA_OUT <= ((mode_r == M_SEQ2) | on_mode) & cfg_r[`DSPS_CFG_LDOA_EN];
      DPD_FLAG_OUT <= (mode_r == M_DPD);
      MODE_OUT <= mode_r;
      SYS_RESET_OUT <= ~((seq_on | on_mode) & LDO_DIG_OUT & osc_s) | any_rst;
      BOOT_OK_OUT <= on_mode & fls_s;
      BOD_IRQ_OUT <= cfg_r[`DSPS_CFG_BOD_EN] & powered & low_s;
      SYS_CLK_EN_OUT <= on_mode & ((divc_r & div_mask) == 7'h00);
      PERIPH_CLK_EN_OUT <= gate_r & {`DSPS_GATE_W{(mode_r == M_ACT) &
                           ((divc_r & div_mask) == 7'h00)}};
      SENSOR_CLK_EN_OUT <= powered & tick_rise;
    end
  end

endmodule // dsps_top

//--- test/dsps_top_chk.sv
// checker: port-level assertions for the power sequencer top
// assumes bind to dsps_top, single clock CLK_IN, sync active-high RST_IN
`timescale 1ns/100ps
module dsps_chk (
  input wire CLK_IN,
  input wire RST_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PREADY_OUT,
  input wire BAT_ABOVE_IN,
  input wire FIELD_ABOVE_IN,
  input wire BAT_SWITCH_OUT,
  input wire FIELD_SWITCH_OUT,
  input wire LDO_DIG_OUT,
  input wire LDO_ANA_OUT,
  input wire DPD_FLAG_OUT,
  input wire [2:0] MODE_OUT,
  input wire SYS_RESET_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // ----
  // assertions
  // ----
  a_ready_one_wait: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held longer than one cycle");
  a_mode_legal: assert property (MODE_OUT inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6})
    else $error("illegal power mode code");
  a_dpd_flag_mode: assert property (DPD_FLAG_OUT == (MODE_OUT == 3'h6))
    else $error("deep power-down flag disagrees with mode");
  a_dpd_ldo_off: assert property (MODE_OUT == 3'h6 |-> !LDO_DIG_OUT && !LDO_ANA_OUT)
    else $error("regulator on in deep power-down");
  a_seq_order: assert property ($rose(LDO_ANA_OUT) |-> LDO_DIG_OUT)
    else $error("analog regulator before digital");
  a_reset_release: assert property ($fell(SYS_RESET_OUT) |-> LDO_DIG_OUT)
    else $error("system reset released without digital regulator");
  a_field_closes: assert property ($rose(FIELD_ABOVE_IN) |-> ##[1:6] FIELD_SWITCH_OUT)
    else $error("field switch did not close");
  a_bat_loss: assert property ($fell(BAT_ABOVE_IN) && FIELD_ABOVE_IN
    |-> ##[1:6] (!BAT_SWITCH_OUT && FIELD_SWITCH_OUT))
    else $error("no switchover to field supply");
endmodule // dsps_chk

bind dsps_top dsps_chk u_chk (.CLK_IN, .RST_IN, .PSEL_IN, .PENABLE_IN, .PREADY_OUT,
  .BAT_ABOVE_IN, .FIELD_ABOVE_IN, .BAT_SWITCH_OUT, .FIELD_SWITCH_OUT, .LDO_DIG_OUT,
  .LDO_ANA_OUT, .DPD_FLAG_OUT, .MODE_OUT, .SYS_RESET_OUT);

//--- test/dsps_supply_model.sv
// model of battery, field rectifier, pins, oscillators and flash
// assumes commands from the bench changed at clock edges
`timescale 1ns/100ps
module dsps_supply_model (
  input wire clk_in,
  input wire bat_on_in,
  input wire field_on_in,
  input wire pin_low_in,
  input wire brown_in,
  input wire wake_low_in,
  input wire ldo_dig_in,
  input wire ldo_ana_in,
  output reg bat_above_out,
  output reg field_above_out,
  output wire reset_n_out,
  output wire wake_n_out,
  output wire vdd_low_out,
  output reg slow_tick_out,
  output reg osc_ok_out,
  output reg flash_ok_out
);
  reg [7:0] osc_cnt_r;
  reg [7:0] fl_cnt_r;
  initial begin
    slow_tick_out = 1'b0;
    osc_cnt_r = 8'h00;
    fl_cnt_r = 8'h00;
  end
  // free-running slow oscillator, unrelated phase
  always #15259 slow_tick_out = ~slow_tick_out;
  // ----
  // comparators and settling
  // ----
  always @(posedge clk_in) begin
    bat_above_out <= bat_on_in;
    field_above_out <= field_on_in;
    osc_cnt_r <= ldo_dig_in ? osc_cnt_r + {7'h00, osc_cnt_r != 8'hFF} : 8'h00;
    fl_cnt_r <= ldo_ana_in ? fl_cnt_r + {7'h00, fl_cnt_r != 8'hFF} : 8'h00;
    osc_ok_out <= osc_cnt_r > 8'h32;
    flash_ok_out <= fl_cnt_r > 8'h64;
  end
  assign reset_n_out = !pin_low_in;
  assign wake_n_out = !wake_low_in; // held high ahead of deep power-down, pulsed low
  assign vdd_low_out = brown_in;
endmodule // dsps_supply_model

//--- test/dual_source_power_sequencer_tb_top.sv
// bench: apb register tests, source selection, start-up and power modes
// assumes dsps_top, supply model and bound checker
`timescale 1ns/100ps
module dual_source_power_sequencer_tb_top;
  reg clk, rst, psel, penable, pwrite, bat_on, field_on, pin_low, brown, csleep, wdt_int, tmatch;
  reg wdt_rst, start_int, wake_low;
  reg [11:0] paddr;
  reg [31:0] pwdata, rdv;
  reg err;
  wire [31:0] prdata;
  wire pready, pslverr, bat_a, fld_a, rst_n, wake_n, vlow, tick, osc_ok, fl_ok;
  wire bat_sw, fld_sw, comp_en, ldo_d, ldo_a, dpd, sys_rst, boot, brownout_detector, sclk_en, sens_en;
  wire [2:0] mode;
  wire [7:0] pclk_en;
  integer miscompares, num_checks, cyc, cnt, i;
  always #20 clk = ~clk;
  dsps_top DUT (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .BAT_ABOVE_IN(bat_a), .FIELD_ABOVE_IN(fld_a),
    .VDD_LOW_IN(vlow), .EXT_RESET_N_IN(rst_n), .WAKE_PIN_IN(wake_n), .SLOW_TICK_IN(tick),
    .FAST_OSC_OK_IN(osc_ok), .FLASH_READY_IN(fl_ok), .TIMER_MATCH_IN(tmatch),
    .WDT_INT_IN(wdt_int), .WDT_RST_IN(wdt_rst), .START_INT_IN(start_int),
    .CORE_SLEEP_IN(csleep),
    .BAT_SWITCH_OUT(bat_sw), .FIELD_SWITCH_OUT(fld_sw), .COMPARATOR_EN_OUT(comp_en),
    .LDO_DIG_OUT(ldo_d), .LDO_ANA_OUT(ldo_a), .DPD_FLAG_OUT(dpd), .MODE_OUT(mode),
    .SYS_RESET_OUT(sys_rst), .BOOT_OK_OUT(boot), .BOD_IRQ_OUT(brownout_detector), .SYS_CLK_EN_OUT(sclk_en),
    .PERIPH_CLK_EN_OUT(pclk_en), .SENSOR_CLK_EN_OUT(sens_en));
  dsps_supply_model u_sup (.clk_in(clk), .bat_on_in(bat_on), .field_on_in(field_on),
    .pin_low_in(pin_low), .brown_in(brown), .wake_low_in(wake_low), .ldo_dig_in(ldo_d),
    .ldo_ana_in(ldo_a),
    .bat_above_out(bat_a), .field_above_out(fld_a), .reset_n_out(rst_n),
    .wake_n_out(wake_n), .vdd_low_out(vlow), .slow_tick_out(tick), .osc_ok_out(osc_ok),
    .flash_ok_out(fl_ok));
  // ----
  // shared tasks
  // ----
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      chk(rdv, exp);
    end
  endtask
  task wait_mode(input logic [2:0] m, input integer lim);
    begin
      cyc = 0;
      while (mode !== m && cyc < lim) begin
        @(posedge clk);
        cyc = cyc + 1;
      end
      chk(mode, m);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #4000000;
    miscompares = miscompares + 1;
    summarize;
  end
  // ----
  // main sequence
  // ----
  initial begin
    {clk, psel, penable, pwrite, field_on, pin_low, brown, csleep, wdt_int, tmatch} = 10'h000;
    {rst, bat_on, paddr, pwdata} = {2'b11, 44'h0};
    {wdt_rst, start_int, wake_low} = 3'h0;
    miscompares = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    chk(bat_sw, 1'b0);
    chk(mode, 3'h0);
    pin_low <= 1'b1;
    repeat (5) @(posedge clk);
    pin_low <= 1'b0;
    wait_mode(3'h1, 20);
    wait_mode(3'h3, 70000);
    chk(cyc > 61900 && cyc < 63500, 1);
    chk({bat_sw, ldo_d, ldo_a, sys_rst, boot}, 5'h1D);
    rd(12'h004, 32'h18);
    rd(12'h00C, 32'h4);
    rd(12'h010, 32'hFF);
    for (i = 0; i < 5; i = i + 1) apb(1'b1, 12'h020 + 4 * i, 32'hA5A50000 + i);
    for (i = 0; i < 5; i = i + 1) rd(12'h020 + 4 * i, 32'hA5A50000 + i);
    rd(12'h100, 32'h0);
    chk(err, 1'b1);
    for (i = 0; i < 8; i = i + 1) begin
      apb(1'b1, 12'h00C, i);
      repeat (256) @(posedge clk);
      cnt = 0;
      repeat (256) @(posedge clk) cnt = cnt + sclk_en;
      chk(cnt, 256 >> i);
    end
    apb(1'b1, 12'h00C, 32'h4);
    apb(1'b1, 12'h010, 32'h1);
    @(posedge clk);
    cnt = 0;
    i = 0;
    repeat (256) @(posedge clk) begin
      cnt = cnt + pclk_en[0];
      i = i + pclk_en[7];
    end
    chk(cnt, 16);
    chk(i, 0);
    cnt = 0;
    repeat (1000) @(posedge clk) cnt = cnt + sens_en;
    chk(cnt > 0 && cnt < 3, 1);
    apb(1'b1, 12'h00C, 32'h2);
    wdt_rst <= 1'b1;
    @(posedge clk);
    wdt_rst <= 1'b0;
    rd(12'h00C, 32'h4);
    apb(1'b1, 12'h00C, 32'h2);
    apb(1'b1, 12'h004, 32'h1C);
    rd(12'h00C, 32'h4);
    rd(12'h004, 32'h18);
    brown <= 1'b1;
    repeat (10) @(posedge clk);
    chk(brownout_detector, 1'b0);
    apb(1'b1, 12'h004, 32'h1A);
    repeat (10) @(posedge clk);
    chk(brownout_detector, 1'b1);
    brown <= 1'b0;
    apb(1'b1, 12'h004, 32'h18);
    field_on <= 1'b1;
    repeat (10) @(posedge clk);
    chk({bat_sw, fld_sw}, 2'b11);
    bat_on <= 1'b0;
    repeat (10) @(posedge clk);
    chk({bat_sw, fld_sw}, 2'b01);
    bat_on <= 1'b1;
    repeat (10) @(posedge clk);
    chk(bat_sw, 1'b1);
    apb(1'b1, 12'h000, 32'h4);
    repeat (3) @(posedge clk);
    chk({bat_sw, fld_sw}, 2'b01);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h19);
    repeat (10) @(posedge clk);
    chk({comp_en, bat_sw}, 2'b01);
    apb(1'b1, 12'h004, 32'h18);
    field_on <= 1'b0;
    csleep <= 1'b1;
    wait_mode(3'h5, 50);
    csleep <= 1'b0;
    chk({ldo_d, ldo_a, dpd}, 3'b110);
    wdt_int <= 1'b1;
    wait_mode(3'h3, 50);
    wdt_int <= 1'b0;
    csleep <= 1'b1;
    wait_mode(3'h5, 50);
    csleep <= 1'b0;
    start_int <= 1'b1;
    wait_mode(3'h3, 50);
    start_int <= 1'b0;
    apb(1'b1, 12'h000, 32'h1);
    csleep <= 1'b1;
    wait_mode(3'h6, 50);
    csleep <= 1'b0;
    chk({ldo_d, ldo_a, dpd}, 3'b001);
    wdt_int <= 1'b1;
    repeat (20) @(posedge clk);
    chk(mode, 3'h6);
    wdt_int <= 1'b0;
    apb(1'b1, 12'h008, 32'h1);
    wake_low <= 1'b1;
    repeat (1000) @(posedge clk);
    wake_low <= 1'b0;
    repeat (10) @(posedge clk);
    chk(mode, 3'h6);
    tmatch <= 1'b1;
    cyc = 0;
    while (mode === 3'h6 && cyc < 50) begin
      @(posedge clk);
      cyc = cyc + 1;
    end
    chk(mode !== 3'h6, 1);
    rd(12'h000, 32'h301);
    apb(1'b1, 12'h000, 32'h302);
    wait_mode(3'h0, 20);
    chk(bat_sw, 1'b0);
    rd(12'h000, 32'h2);
    summarize;
  end
endmodule // dual_source_power_sequencer_tb_top
